//--- rtl/ppd_pkg.sv
// Overview of operation
// - When the calibration clock enable bit is set the calibration clock drives timer pin 1, otherwise that output is off.
// - The factory test register reads at any time and accepts writes only in special mode.
// - Port C polarity bits 7 to 1 pick pulldown when 1 and pullup when 0, effective only while the pull is enabled.
// - On port C bit 0 and port S bit 4, with the CAN receiver active and routed there, only a pullup is allowed and choosing pulldown turns the pull off.
// - Port S polarity bits 7 to 5 and 3 to 0 pick pulldown with rising edge when 1, pullup with falling edge when 0.
// - The port data register holds the level driven on each general-purpose output pin.
// - Port data reads give the latch for output bits and the buffered pin for input bits.
// - Port input reads always give the buffered pin state whatever the direction.
// - The port input register is read-only and writes to it change nothing.
// - A pin not claimed by a peripheral works as general-purpose I/O under the port registers.
// - A direction bit of 1 makes the pin an output, 0 an input.
// - After a direction change, data and input reads may take up to two clocks to settle through the synchronisers.
package ppd_pkg;
  localparam logic [9:0] OFS_MISC    = 10'h20c;
  localparam logic [9:0] OFS_FTEST   = 10'h20e;
  localparam logic [9:0] OFS_CPOL    = 10'h210;
  localparam logic [9:0] OFS_SPOL    = 10'h211;
  localparam logic [9:0] OFS_DATA    = 10'h212;
  localparam logic [9:0] OFS_PIN     = 10'h213;
  localparam logic [9:0] OFS_DIR     = 10'h214;
  localparam logic [9:0] OFS_PULLEN  = 10'h215;
  localparam int         MISC_CALE   = 0;
  localparam int         CAN_C_BIT   = 0;
  localparam int         CAN_S_BIT   = 4;
  localparam logic [7:0] RST_MISC    = 8'h00;
  localparam logic [7:0] RST_FTEST   = 8'h00;
  localparam logic [7:0] RST_PPS     = 8'h00;
  localparam logic [7:0] RST_DATA    = 8'h00;
  localparam logic [7:0] RST_DIR     = 8'h00;
  localparam logic [7:0] RST_PULLEN  = 8'h00;
  localparam int         SYNC_STAGES = 2;
endpackage

//--- rtl/ppd_port_if.sv
`timescale 1ns/100ps
// Per-port configuration and pin state between top and pin logic
interface ppd_port_if #(parameter int W = 8);
  logic [W-1:0] out_bits;
  logic [W-1:0] dir_bits;
  logic [W-1:0] pull_en;
  logic [W-1:0] pol_bits;
  logic [W-1:0] pin_sync;
  logic [W-1:0] pad_out;
  logic [W-1:0] pad_oe;
  logic [W-1:0] pull_up;
  logic [W-1:0] pull_dn;
  modport ctrl (output out_bits, output dir_bits, output pull_en, output pol_bits,
                input pin_sync, input pad_out, input pad_oe, input pull_up, input pull_dn);
  modport pins (input out_bits, input dir_bits, input pull_en, input pol_bits,
                output pin_sync, output pad_out, output pad_oe, output pull_up,
                output pull_dn);
endinterface

//--- rtl/ppd_sync.sv
`timescale 1ns/100ps
module ppd_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import ppd_pkg::*;
  logic [W-1:0] meta_q;
  // Two-stage input synchroniser
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

//--- rtl/ppd_pin.sv
`timescale 1ns/100ps
module ppd_pin #(
  parameter int         W        = 8,
  parameter logic [7:0] EDGE_MSK = 8'h00,
  parameter int         CAN_BIT  = 0
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Pads
  input  wire logic [W-1:0] pad_in,
  input  wire logic         can_active,
  output logic      [W-1:0] edge_rise,
  ppd_port_if.pins          port
);
  import ppd_pkg::*;
  // Synchronised pin levels
  ppd_sync #(.W(W)) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (pad_in),
    .q     (port.pin_sync)
  );
  // Output drive and pull selection per bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    wire inp = ~port.dir_bits[i];
    wire can = (i == CAN_BIT) && can_active;
    assign port.pad_out[i] = port.out_bits[i];
    assign port.pad_oe[i]  = port.dir_bits[i];
    assign port.pull_up[i] = inp & port.pull_en[i] & ~port.pol_bits[i];
    assign port.pull_dn[i] = inp & port.pull_en[i] & port.pol_bits[i] & ~can;
    assign edge_rise[i]    = EDGE_MSK[i] & port.pol_bits[i];
  end
endmodule

//--- rtl/ppd_top.sv
// Chosen here: the strobed register port.
`timescale 1ns/100ps
module ppd_top (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // Register port
  input  wire logic [9:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Mode and peripheral status
  input  wire logic       special_mode,
  input  wire logic       can_active_c,
  input  wire logic       can_active_s,
  input  wire logic       rtc_calibration_clock,
  // Timer pin 1
  output logic            timer_port_pin1,
  output logic            timer_port_pin1_oe,
  // Port C pads
  input  wire logic [7:0] pc_in,
  output logic      [7:0] pc_out,
  output logic      [7:0] pc_oe,
  output logic      [7:0] pc_pull_up,
  output logic      [7:0] pc_pull_dn,
  // Port S pads
  input  wire logic [7:0] ps_in,
  output logic      [7:0] ps_out,
  output logic      [7:0] ps_oe,
  output logic      [7:0] ps_pull_up,
  output logic      [7:0] ps_pull_dn,
  output logic      [7:0] ps_edge_rise
);
  import ppd_pkg::*;
  logic       rs1_q;
  logic       rst_n;
  logic [7:0] misc_q;
  logic [7:0] ftest_q;
  logic [7:0] cpol_q;
  logic [7:0] spol_q;
  logic [7:0] data_q;
  logic [7:0] dir_q;
  logic [7:0] pullen_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_d;
  logic [7:0] pc_edge;
  ppd_port_if #(.W(8)) pc_if ();
  ppd_port_if #(.W(8)) ps_if ();

  // Reset release
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rs1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rst_n <= rs1_q;
    end
  end

  // Write decode
  wire we_misc   = wr && addr == OFS_MISC;
  wire we_ftest  = wr && addr == OFS_FTEST && special_mode;
  wire we_cpol   = wr && addr == OFS_CPOL;
  wire we_spol   = wr && addr == OFS_SPOL;
  wire we_data   = wr && addr == OFS_DATA;
  wire we_dir    = wr && addr == OFS_DIR;
  wire we_pullen = wr && addr == OFS_PULLEN;

  // Register writes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      misc_q   <= RST_MISC;
      ftest_q  <= RST_FTEST;
      cpol_q   <= RST_PPS;
      spol_q   <= RST_PPS;
      data_q   <= RST_DATA;
      dir_q    <= RST_DIR;
      pullen_q <= RST_PULLEN;
    end else begin
      if (we_misc)   misc_q   <= {7'h00, wdata[MISC_CALE]};
      if (we_ftest)  ftest_q  <= wdata;
      if (we_cpol)   cpol_q   <= wdata;
      if (we_spol)   spol_q   <= wdata;
      if (we_data)   data_q   <= wdata;
      if (we_dir)    dir_q    <= wdata;
      if (we_pullen) pullen_q <= wdata;
    end
  end

  // Port configuration to pin logic; port S shares direction and pull enables
  assign pc_if.out_bits = data_q;
  assign pc_if.dir_bits = dir_q;
  assign pc_if.pull_en  = pullen_q;
  assign pc_if.pol_bits = cpol_q;
  assign ps_if.out_bits = data_q;
  assign ps_if.dir_bits = dir_q;
  assign ps_if.pull_en  = pullen_q;
  assign ps_if.pol_bits = spol_q;

  ppd_pin #(.W(8), .EDGE_MSK(8'h00), .CAN_BIT(CAN_C_BIT)) u_pc (
    .clock      (clock),
    .rst_n      (rst_n),
    .pad_in     (pc_in),
    .can_active (can_active_c),
    .edge_rise  (pc_edge),
    .port       (pc_if.pins)
  );
  ppd_pin #(.W(8), .EDGE_MSK(8'hff), .CAN_BIT(CAN_S_BIT)) u_ps (
    .clock      (clock),
    .rst_n      (rst_n),
    .pad_in     (ps_in),
    .can_active (can_active_s),
    .edge_rise  (ps_edge_rise),
    .port       (ps_if.pins)
  );

  // Pad outputs
  assign pc_out     = pc_if.pad_out;
  assign pc_oe      = pc_if.pad_oe;
  assign pc_pull_up = pc_if.pull_up;
  assign pc_pull_dn = pc_if.pull_dn;
  assign ps_out     = ps_if.pad_out;
  assign ps_oe      = ps_if.pad_oe;
  assign ps_pull_up = ps_if.pull_up;
  assign ps_pull_dn = ps_if.pull_dn;

  // Calibration clock onto timer pin 1
  assign timer_port_pin1    = misc_q[MISC_CALE] & rtc_calibration_clock;
  assign timer_port_pin1_oe = misc_q[MISC_CALE];

  // Read mux
  wire [7:0] data_rd = (dir_q & data_q) | (~dir_q & pc_if.pin_sync);
  always_comb begin
    unique case (addr)
      OFS_MISC:   rd_d = misc_q;
      OFS_FTEST:  rd_d = ftest_q;
      OFS_CPOL:   rd_d = cpol_q;
      OFS_SPOL:   rd_d = spol_q;
      OFS_DATA:   rd_d = data_rd;
      OFS_PIN:    rd_d = pc_if.pin_sync;
      OFS_DIR:    rd_d = dir_q;
      OFS_PULLEN: rd_d = pullen_q;
      default:    rd_d = 8'h00;
    endcase
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) rdata_q <= 8'h00;
    else if (rd) rdata_q <= rd_d;
    else rdata_q <= 8'h00;
  end
  assign rdata = rdata_q;
endmodule

//--- sim/ppd_properties.sv
`timescale 1ns/100ps
module ppd_chk
  import ppd_pkg::*;
(
  // Clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  // Register port
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // Pins
  input wire logic       special_mode,
  input wire logic       can_active_c,
  input wire logic       can_active_s,
  input wire logic       rtc_calibration_clock,
  input wire logic       timer_port_pin1,
  input wire logic       timer_port_pin1_oe,
  input wire logic [7:0] pc_out,
  input wire logic [7:0] pc_oe,
  input wire logic [7:0] pc_pull_dn,
  input wire logic [7:0] ps_pull_up,
  input wire logic [7:0] ps_pull_dn,
  input wire logic [7:0] ps_edge_rise
);
  // One clock domain for all checks
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  cal_gate_a: assert property (timer_port_pin1 == (rtc_calibration_clock & timer_port_pin1_oe))
    else $error("cal clock gating wrong");
  cal_enable_a: assert property (wr && addr == OFS_MISC |=> timer_port_pin1_oe == $past(wdata[0]))
    else $error("cal enable not written");
  s_down_a: assert property ((ps_pull_dn & ~ps_edge_rise) == 8'h00)
    else $error("port s pulldown without rising edge");
  s_up_a: assert property ((ps_pull_up & ps_edge_rise) == 8'h00)
    else $error("port s pullup with rising edge");
  can_c_pull_a: assert property (can_active_c |-> !pc_pull_dn[CAN_C_BIT])
    else $error("port c pulldown while receiver active");
  can_s_pull_a: assert property (can_active_s |-> !ps_pull_dn[CAN_S_BIT])
    else $error("port s pulldown while receiver active");
  pull_input_a: assert property ((pc_pull_dn & pc_oe) == 8'h00)
    else $error("pulldown on output pin");
  data_write_a: assert property (wr && addr == OFS_DATA |=> pc_out == $past(wdata))
    else $error("data latch not written");
  dir_write_a: assert property (wr && addr == OFS_DIR |=> pc_oe == $past(wdata))
    else $error("direction not written");
  pin_ro_a: assert property (wr && addr == OFS_PIN |=> $stable(pc_out) && $stable(pc_oe))
    else $error("input register write had effect");
  read_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  // Main scenarios reached
  cover property (wr && addr == OFS_FTEST && special_mode);
  cover property (can_active_s && ps_edge_rise[4]);
  cover property (rd && addr == OFS_PIN);
endmodule
bind ppd_top ppd_chk i_ppd_chk (.*);

//--- sim/ppd_top_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module ppd_top_tb;
  import ppd_pkg::*;
  logic       clock, resetn, wr, rd, special_mode, can_active_c, can_active_s;
  logic       rtc_calibration_clock, timer_port_pin1, timer_port_pin1_oe;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, pc_in, pc_out, pc_oe, pc_pull_up, pc_pull_dn;
  logic [7:0] ps_in, ps_out, ps_oe, ps_pull_up, ps_pull_dn, ps_edge_rise;
  int         n_errors = 0;
  int         checked = 0;
  ppd_top i_ppd_top (.*);
  // Clock
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  // Register bus cycles
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a; wdata <= d; wr <= 1'h1;
    @(posedge clock);
    wr <= 1'h0;
  endtask
  task automatic rd_chk(input string n, input logic [9:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a; rd <= 1'h1;
    @(posedge clock);
    rd <= 1'h0;
    @(negedge clock);
    `CHK(n, e, rdata)
  endtask
  // Scenarios
  task automatic t_reset;
    rd_chk("misc", OFS_MISC, RST_MISC);
    rd_chk("cpol", OFS_CPOL, RST_PPS);
    rd_chk("dir", OFS_DIR, RST_DIR);
  endtask
  task automatic t_cal;
    wr_reg(OFS_MISC, 8'h01);
    rtc_calibration_clock <= 1'h1;
    @(negedge clock);
    `CHK("cal", 1'h1, timer_port_pin1)
    `CHK("cal_oe", 1'h1, timer_port_pin1_oe)
    wr_reg(OFS_MISC, 8'h00);
    @(negedge clock);
    `CHK("cal_off", 1'h0, timer_port_pin1)
    `CHK("cal_oe_off", 1'h0, timer_port_pin1_oe)
  endtask
  task automatic t_ftest;
    wr_reg(OFS_FTEST, 8'ha5);
    rd_chk("ft_lock", OFS_FTEST, 8'h00);
    @(posedge clock);
    special_mode <= 1'h1;
    wr_reg(OFS_FTEST, 8'ha5);
    rd_chk("ft_open", OFS_FTEST, 8'ha5);
  endtask
  task automatic t_pull;
    wr_reg(OFS_PULLEN, 8'hff);
    wr_reg(OFS_CPOL, 8'haa);
    wr_reg(OFS_SPOL, 8'h5b);
    @(negedge clock);
    `CHK("c_dn", 8'haa, pc_pull_dn)
    `CHK("c_up", 8'h55, pc_pull_up)
    `CHK("s_edge", 8'h5b, ps_edge_rise)
    `CHK("s_dn", 8'h5b, ps_pull_dn)
    @(posedge clock);
    can_active_c <= 1'h1;
    can_active_s <= 1'h1;
    wr_reg(OFS_CPOL, 8'hab);
    @(negedge clock);
    `CHK("can_c_dn", 8'haa, pc_pull_dn)
    `CHK("can_c_up", 8'h54, pc_pull_up)
    `CHK("can_s_dn", 8'h4b, ps_pull_dn)
    `CHK("can_s_up", 8'ha4, ps_pull_up)
    wr_reg(OFS_PULLEN, 8'h00);
    @(negedge clock);
    `CHK("pull_off", 8'h00, pc_pull_up | pc_pull_dn)
  endtask
  task automatic t_data;
    wr_reg(OFS_DIR, 8'hf0);
    wr_reg(OFS_DATA, 8'h3c);
    @(negedge clock);
    `CHK("out", 8'h3c, pc_out)
    `CHK("oe", 8'hf0, pc_oe)
    `CHK("s_out", 8'h3c, ps_out)
    `CHK("s_oe", 8'hf0, ps_oe)
    repeat (3) @(posedge clock);
    rd_chk("data", OFS_DATA, 8'h35);
    rd_chk("pin", OFS_PIN, 8'ha5);
    wr_reg(OFS_PIN, 8'hff);
    rd_chk("pin_ro", OFS_PIN, 8'ha5);
    `CHK("out_kept", 8'h3c, pc_out)
    rd_chk("unmapped", 10'h3ff, 8'h00);
    // New pin level shows only after the two synchroniser stages
    pc_in <= 8'h5a;
    rd_chk("pin_lag", OFS_PIN, 8'ha5);
    rd_chk("pin_new", OFS_PIN, 8'h5a);
  endtask
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (2000) @(posedge clock);
    n_errors++;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    resetn = 1'h0; addr = 10'h000; wdata = 8'h00; wr = 1'h0; rd = 1'h0;
    special_mode = 1'h0; can_active_c = 1'h0; can_active_s = 1'h0;
    rtc_calibration_clock = 1'h0; pc_in = 8'ha5; ps_in = 8'h00;
    repeat (12) @(posedge clock);
    resetn <= 1'h1;
    repeat (3) @(posedge clock);
    t_reset;
    t_cal;
    t_ftest;
    t_pull;
    t_data;
    tally_and_finish;
  end
endmodule
